// [logic/csa_pkg.sv]
// Constants for the controlled sequence advance block.
// Assumes a 32-bit Avalon-MM register bus and a 125 MHz core clock.
package csa_pkg;
  // Register word byte offsets
  localparam logic [4:0] CSA_REG_CTRL   = 5'h00;
  localparam logic [4:0] CSA_REG_TOTAL  = 5'h04;
  localparam logic [4:0] CSA_REG_STEP   = 5'h08;
  localparam logic [4:0] CSA_REG_SETIDX = 5'h0c;
  localparam logic [4:0] CSA_REG_SETDAT = 5'h10;
  localparam logic [4:0] CSA_REG_ACTIVE = 5'h14;
  localparam logic [4:0] CSA_REG_STATUS = 5'h18;

  // Control and status field positions
  localparam int CSA_CTRL_EN      = 0;
  localparam int CSA_CTRL_ADV_LO  = 1;
  localparam int CSA_CTRL_RST_LO  = 3;
  localparam int CSA_CTRL_INV1    = 5;
  localparam int CSA_CTRL_INV2    = 6;
  localparam int CSA_CTRL_FALL    = 7;
  localparam int CSA_STAT_EN      = 8;
  localparam int CSA_STAT_WAIT    = 9;

  // Set store geometry
  localparam int CSA_SETS         = 64;
  localparam int CSA_IDX_W        = 6;
  localparam int CSA_CNT_W        = 7;
  localparam int CSA_PAR_W        = 32;
  localparam logic [CSA_CNT_W-1:0] CSA_TOTAL_MAX = 7'h40;
  localparam logic [CSA_CNT_W-1:0] CSA_TOTAL_RST = 7'h40;
  localparam logic [CSA_PAR_W-1:0] CSA_ACTIVE_RST = 32'h0000_0000;

  // Advance source and restart source codes
  localparam logic [1:0] CSA_ADV_ALWAYS = 2'h0;
  localparam logic [1:0] CSA_ADV_LINE1  = 2'h1;
  localparam logic [1:0] CSA_ADV_LINE2  = 2'h2;
  localparam logic [1:0] CSA_ADV_OFF    = 2'h3;
  localparam logic [1:0] CSA_RST_NONE   = 2'h0;
  localparam logic [1:0] CSA_RST_LINE1  = 2'h1;
  localparam logic [1:0] CSA_RST_LINE2  = 2'h2;

  // Line settle window after a level change
  localparam int CSA_CLK_MHZ    = 125;
  localparam int CSA_SETTLE_US  = 1;
  localparam int CSA_SETTLE_CYC = CSA_SETTLE_US * CSA_CLK_MHZ;
  localparam int CSA_SET_CNT_W  = 8;

  // Bus access phases
  typedef enum logic [1:0] {CSA_BUS_IDLE, CSA_BUS_FETCH, CSA_BUS_DONE} csa_bus_t;
endpackage : csa_pkg

// [logic/csa_set_mem.sv]
// Store of sequence parameter sets, one word per set.
// Assumes one write and one read port; read data come from a register.
`timescale 1ns/1ps
module csa_set_mem (
  // Clock
  input  wire logic                                     core_clk_i,
  // Write port
  input  wire logic                                     wr_en_i,
  input  wire logic [csa_pkg::CSA_IDX_W-1:0]            wr_addr_i,
  input  wire logic [csa_pkg::CSA_PAR_W-1:0]            wr_data_i,
  // Read port
  input  wire logic                                     rd_en_i,
  input  wire logic [csa_pkg::CSA_IDX_W-1:0]            rd_addr_i,
  output logic      [csa_pkg::CSA_PAR_W-1:0]            rd_data_o
);
  import csa_pkg::*;

  logic [CSA_PAR_W-1:0] mem_q [CSA_SETS];

  // Write storage
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read
  always_ff @(posedge core_clk_i) begin
    if (rd_en_i) begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end
endmodule : csa_set_mem

// [logic/csa_sequencer.sv]
// Controlled sequence advance sequencer with Avalon-MM register slave.
// Assumes frame trigger and input lines are synchronous to core_clk_i.
//
// Operation
// [RQ1] Sets step upward in index order, governed by the chosen advance source.
// [RQ2] Always-active source advances on every accepted frame trigger.
// [RQ3] Line one or line two source decides advance from that line's level.
// [RQ4] Disabled source changes sets only on a software step command; the code also restarts to set 0 on a restart line.
// [RQ5] Cycle length is programmable, 1 to 64, indices 0 to count minus one.
// [RQ6] Enabling loads stored set 0 into the active set.
// [RQ7] Always-active: first acquisition after enabling uses set 1.
// [RQ8] After the last index the next advance wraps to set 0.
// [RQ9] Disabling stops cycling and restores the pre-enable active values.
// [RQ10] Restart source selectable as line one or line two.
// [RQ11] Restart line high at a trigger starts a new cycle on set 0.
// [RQ12] Restart wins over advance at the same trigger.
// [RQ13] While a line changes level, waiting-for-trigger status drops.
// [RQ14] Per-line invert; with invert off, high means asserted.
// [RQ15] Decisions are taken at the configured frame trigger edge.
// [RQ16] Line source: high loads next set, low keeps the current set.
// [RQ17] Triggers arriving while a line settles are ignored.
// [RQ18] Outside party must pick the other line for restart than for advance.
// [RQ19] Each software step moves forward by one, wrapping after the last.
`timescale 1ns/1ps
module csa_sequencer (
  // Clock and reset
  input  wire logic                                     core_clk_i,
  input  wire logic                                     srst_i,
  // Avalon-MM slave
  input  wire logic [4:0]                               avs_address_i,
  input  wire logic                                     avs_read_i,
  input  wire logic                                     avs_write_i,
  input  wire logic [31:0]                              avs_writedata_i,
  output logic      [31:0]                              avs_readdata_o,
  output logic                                          avs_waitrequest_o,
  // Trigger and control lines
  input  wire logic                                     frame_trigger_i,
  input  wire logic [1:0]                               input_line_i,
  // Sequencer outputs
  output logic      [csa_pkg::CSA_PAR_W-1:0]            active_params_o,
  output logic      [csa_pkg::CSA_IDX_W-1:0]            set_index_o,
  output logic                                          frame_accept_o,
  output logic                                          waiting_trigger_o
);
  import csa_pkg::*;

  localparam logic [CSA_SET_CNT_W-1:0] SETTLE_LOAD = CSA_SET_CNT_W'(CSA_SETTLE_CYC);

  // Configuration state
  logic                  enable_q;
  logic [1:0]            adv_src_q;
  logic [1:0]            rst_src_q;
  logic [1:0]            invert_q;
  logic                  fall_edge_q;
  logic [CSA_CNT_W-1:0]  total_q;
  logic [CSA_IDX_W-1:0]  mem_idx_q;
  // Sequencer state
  logic                  enable_d1_q;
  logic [CSA_IDX_W-1:0]  idx_q;
  logic [CSA_PAR_W-1:0]  active_q;
  logic [CSA_PAR_W-1:0]  shadow_q;
  logic                  load_q;
  logic                  trig_q;
  logic [1:0]            line_q;
  logic [CSA_SET_CNT_W-1:0] settle_q;
  logic                  accept_q;
  // Bus state
  csa_bus_t              bus_q;
  logic [31:0]           rdata_q;

  // Combinational terms
  logic                  trig_edge;
  logic [1:0]            line_eff;
  logic                  settling;
  logic                  accept;
  logic                  restart_hit;
  logic                  adv_hit;
  logic                  enable_rise;
  logic                  enable_fall;
  logic                  bus_req;
  logic                  bus_take;
  logic                  bus_wr;
  logic                  sw_step;
  logic                  seq_rd;
  logic [CSA_IDX_W-1:0]  wrap_idx;
  logic [CSA_IDX_W-1:0]  next_idx;
  logic                  mem_rd_en;
  logic [CSA_IDX_W-1:0]  mem_rd_addr;
  logic [CSA_PAR_W-1:0]  mem_rd_data;

  // Edge, invert and settle qualification
  assign trig_edge   = fall_edge_q ? (trig_q & ~frame_trigger_i)
                                   : (~trig_q & frame_trigger_i); // see [RQ15]
  assign line_eff    = input_line_i ^ invert_q;                   // see [RQ14]
  assign settling    = (settle_q != '0) || (input_line_i != line_q);
  assign accept      = enable_q & enable_d1_q & trig_edge & ~settling; // see [RQ17]
  assign enable_rise = enable_q & ~enable_d1_q;
  assign enable_fall = ~enable_q & enable_d1_q;

  // Restart source decode
  always_comb begin
    case (rst_src_q)
      CSA_RST_LINE1: restart_hit = line_eff[0]; // see [RQ10]
      CSA_RST_LINE2: restart_hit = line_eff[1]; // see [RQ10]
      default:       restart_hit = 1'b0;
    endcase
  end

  // Advance source decode
  always_comb begin
    case (adv_src_q)
      CSA_ADV_ALWAYS: adv_hit = 1'b1;        // see [RQ2]
      CSA_ADV_LINE1:  adv_hit = line_eff[0]; // see [RQ3] see [RQ16]
      CSA_ADV_LINE2:  adv_hit = line_eff[1]; // see [RQ3] see [RQ16]
      default:        adv_hit = 1'b0;        // see [RQ4]
    endcase
  end

  // Bus request decode
  assign bus_req   = avs_read_i | avs_write_i;
  assign bus_wr    = avs_write_i & (bus_q == CSA_BUS_DONE);
  assign sw_step   = bus_wr & (avs_address_i == CSA_REG_STEP) & avs_writedata_i[0];

  // Index stepping with wrap
  assign wrap_idx = (CSA_CNT_W'(idx_q) + 7'h01 >= total_q) ? '0 : idx_q + 6'h01; // see [RQ8]
  always_comb begin
    next_idx = idx_q;
    if (enable_rise) begin
      next_idx = '0;                                 // see [RQ6]
    end else if (accept && restart_hit) begin
      next_idx = '0;                                 // see [RQ11] see [RQ12]
    end else if (accept && adv_hit) begin
      next_idx = wrap_idx;                           // see [RQ1] see [RQ7]
    end else if (enable_q && enable_d1_q && sw_step) begin
      next_idx = wrap_idx;                           // see [RQ19]
    end
  end

  // Sequencer owns the memory read port when a set must load
  assign seq_rd      = enable_rise | (enable_q & enable_d1_q & (accept | sw_step));
  assign bus_take    = bus_req & (bus_q == CSA_BUS_IDLE) & ~seq_rd;
  assign mem_rd_en   = seq_rd | bus_take;
  assign mem_rd_addr = seq_rd ? next_idx : mem_idx_q;

  csa_set_mem u_set_mem (
    .core_clk_i (core_clk_i),
    .wr_en_i    (bus_wr & (avs_address_i == CSA_REG_SETDAT)),
    .wr_addr_i  (mem_idx_q),
    .wr_data_i  (avs_writedata_i),
    .rd_en_i    (mem_rd_en),
    .rd_addr_i  (mem_rd_addr),
    .rd_data_o  (mem_rd_data)
  );

  // Input sampling and trigger history
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      trig_q <= 1'b0;
      line_q <= 2'h0;
    end else begin
      trig_q <= frame_trigger_i;
      line_q <= input_line_i;
    end
  end

  // Settle window after any line change
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      settle_q <= '0;
    end else if (input_line_i != line_q) begin
      settle_q <= SETTLE_LOAD;                       // see [RQ13]
    end else if (settle_q != '0) begin
      settle_q <= settle_q - 8'h01;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      enable_q    <= 1'b0;
      adv_src_q   <= CSA_ADV_ALWAYS;
      rst_src_q   <= CSA_RST_NONE;
      invert_q    <= 2'h0;
      fall_edge_q <= 1'b0;
      total_q     <= CSA_TOTAL_RST;
      mem_idx_q   <= '0;
    end else if (bus_wr) begin
      case (avs_address_i)
        CSA_REG_CTRL: begin
          enable_q    <= avs_writedata_i[CSA_CTRL_EN];
          adv_src_q   <= avs_writedata_i[CSA_CTRL_ADV_LO +: 2];
          rst_src_q   <= avs_writedata_i[CSA_CTRL_RST_LO +: 2];
          invert_q    <= {avs_writedata_i[CSA_CTRL_INV2], avs_writedata_i[CSA_CTRL_INV1]};
          fall_edge_q <= avs_writedata_i[CSA_CTRL_FALL];
        end
        CSA_REG_TOTAL: begin
          if (avs_writedata_i[CSA_CNT_W-1:0] != '0 &&
              avs_writedata_i[CSA_CNT_W-1:0] <= CSA_TOTAL_MAX &&
              avs_writedata_i[31:CSA_CNT_W] == '0) begin
            total_q <= avs_writedata_i[CSA_CNT_W-1:0]; // see [RQ5]
          end
        end
        CSA_REG_SETIDX: mem_idx_q <= avs_writedata_i[CSA_IDX_W-1:0];
        default: ;
      endcase
    end
  end

  // Enable history and current index
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      enable_d1_q <= 1'b0;
      idx_q       <= '0;
      load_q      <= 1'b0;
      accept_q    <= 1'b0;
    end else begin
      enable_d1_q <= enable_q;
      idx_q       <= next_idx;
      load_q      <= seq_rd;
      accept_q    <= accept;
    end
  end

  // Active set: load from store, save and restore around enable
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      active_q <= CSA_ACTIVE_RST;
      shadow_q <= CSA_ACTIVE_RST;
    end else begin
      if (enable_rise) begin
        shadow_q <= active_q;                        // see [RQ9]
      end
      if (enable_fall) begin
        active_q <= shadow_q;                        // see [RQ9]
      end else if (load_q && enable_q) begin
        active_q <= mem_rd_data;                     // see [RQ6]
      end else if (bus_wr && avs_address_i == CSA_REG_ACTIVE && !enable_q) begin
        active_q <= avs_writedata_i;
      end
    end
  end

  // Bus access phases: fetch, then answer
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bus_q <= CSA_BUS_IDLE;
    end else begin
      case (bus_q)
        CSA_BUS_IDLE:  bus_q <= bus_take ? CSA_BUS_FETCH : CSA_BUS_IDLE;
        CSA_BUS_FETCH: bus_q <= CSA_BUS_DONE;
        CSA_BUS_DONE:  bus_q <= CSA_BUS_IDLE;
        default:       bus_q <= CSA_BUS_IDLE;
      endcase
    end
  end

  // Read data capture
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_q == CSA_BUS_FETCH) begin
      case (avs_address_i)
        CSA_REG_CTRL:   rdata_q <= {24'h00_0000, fall_edge_q, invert_q, rst_src_q,
                                    adv_src_q, enable_q};
        CSA_REG_TOTAL:  rdata_q <= {25'h000_0000, total_q};
        CSA_REG_SETIDX: rdata_q <= {26'h000_0000, mem_idx_q};
        CSA_REG_SETDAT: rdata_q <= mem_rd_data;
        CSA_REG_ACTIVE: rdata_q <= active_q;
        CSA_REG_STATUS: rdata_q <= {22'h00_0000, ~settling, enable_q, 2'h0, idx_q};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Outputs
  assign avs_waitrequest_o = ~(bus_q == CSA_BUS_DONE);
  assign avs_readdata_o    = rdata_q;
  assign active_params_o   = active_q;
  assign set_index_o       = idx_q;
  assign frame_accept_o    = accept_q;
  assign waiting_trigger_o = ~settling;              // see [RQ13]
endmodule : csa_sequencer

// [tb/csa_sequencer_asserts.sv]
// Port checker for the controlled sequence advance sequencer.
// Assumes a bind onto csa_sequencer; one clock, synchronous active-high reset.
`timescale 1ns/1ps
module csa_sequencer_asserts (
  // Clock and reset
  input wire logic                            core_clk_i,
  input wire logic                            srst_i,
  // Bus handshake
  input wire logic                            avs_read_i,
  input wire logic                            avs_write_i,
  input wire logic                            avs_waitrequest_o,
  // Trigger side
  input wire logic [1:0]                      input_line_i,
  input wire logic [csa_pkg::CSA_IDX_W-1:0]   set_index_o,
  input wire logic                            frame_accept_o,
  input wire logic                            waiting_trigger_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for two cycles");
  a_wait_cause: assert property (!avs_waitrequest_o |-> (avs_read_i || avs_write_i))
    else $error("waitrequest low without a request");
  a_answer_bound: assert property ($rose(avs_read_i || avs_write_i) |-> ##[1:20] !avs_waitrequest_o)
    else $error("bus request not answered in time");
  a_index_steps: assert property ($changed(set_index_o) |-> set_index_o == 6'h0 || set_index_o == $past(set_index_o) + 6'h1 || $past(avs_write_i))
    else $error("set index jumped");
  a_index_cause: assert property ($changed(set_index_o) |-> frame_accept_o || $past(avs_write_i) || $past(avs_write_i, 2) || $past(avs_write_i, 3))
    else $error("set index moved without a cause");
  a_accept_pulse: assert property (frame_accept_o |=> !frame_accept_o)
    else $error("accept pulse longer than one cycle");
  a_accept_waiting: assert property (frame_accept_o |-> $past(waiting_trigger_o))
    else $error("trigger accepted while not waiting");
  a_wait_drop: assert property ($changed(input_line_i) |-> !waiting_trigger_o [*8])
    else $error("still waiting while a line settles");
  a_ignore_settle: assert property ($changed(input_line_i) |=> !frame_accept_o [*8])
    else $error("trigger accepted during settle");
endmodule : csa_sequencer_asserts

// [tb/csa_line_model.sv]
// Frame trigger source and input line drivers facing the sequencer.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module csa_line_model (
  // Clock
  input  wire logic       core_clk_i,
  // Device status
  input  wire logic       waiting_i,
  // Driven to the device
  output logic            trig_o,
  output logic [1:0]      lines_o
);
  // Idle levels
  initial begin
    trig_o = 1'b0;
    lines_o = 2'h0;
  end
  // Line change with a settle margin on both sides
  task automatic set_lines(input logic [1:0] v);
    if (v != lines_o) begin
      repeat (130) @(posedge core_clk_i);  // Hold after last trigger
      lines_o <= v;
      repeat (130) @(posedge core_clk_i);  // Settle before next trigger
    end
  endtask : set_lines
  // One trigger pulse, once the device waits or after a 400-cycle timeout
  task automatic pulse();
    int n;
    n = 0;
    while (waiting_i !== 1'b1 && n < 400) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 400) begin
      csa_sequencer_tb.errors++;
      $display("[FAIL] %0t trigger wait timed out", $time);
    end
    @(posedge core_clk_i);
    trig_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    trig_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : pulse
  // Faulty pulse: trigger rises at the same edge as a line change
  task automatic glitch(input logic [1:0] v);
    @(posedge core_clk_i);
    lines_o <= v;
    trig_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    trig_o <= 1'b0;
    repeat (130) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : glitch
endmodule : csa_line_model

// [tb/csa_sequencer_tb.sv]
// Self-checking bench for the controlled sequence advance sequencer.
// Assumes csa_pkg register map; partner model drives trigger and lines.
`timescale 1ns/1ps
module csa_sequencer_tb;
  import csa_pkg::*;
  logic        core_clk_i;
  logic        srst_i;
  logic [4:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        frame_trigger_i;
  logic [1:0]  input_line_i;
  logic [31:0] active_params_o;
  logic [5:0]  set_index_o;
  logic        frame_accept_o;
  logic        waiting_trigger_o;
  logic [31:0] mem [0:5];
  logic [5:0]  exp_idx;
  int          errors;
  int          num_checks;

  csa_sequencer i_csa_sequencer (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .frame_trigger_i(frame_trigger_i),
    .input_line_i(input_line_i), .active_params_o(active_params_o),
    .set_index_o(set_index_o), .frame_accept_o(frame_accept_o),
    .waiting_trigger_o(waiting_trigger_o));
  csa_line_model i_csa_line_model (.core_clk_i(core_clk_i), .waiting_i(waiting_trigger_o),
    .trig_o(frame_trigger_i), .lines_o(input_line_i));

  // Clock, 8 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // Verdict and end of run
  task automatic tally_and_finish;
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // Compare tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_idx(input logic [5:0] got, input logic [5:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t index %0d expected %0d", $time, got, exp);
    end
  endtask : chk_idx
  // One Avalon-MM access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int   n;
    logic wq;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    // Request stands until the rising edge that samples waitrequest low
    do begin
      @(posedge core_clk_i);
      n++;
      wq = avs_waitrequest_o;
    end while (wq !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (wq !== 1'b0) begin
      errors++;
      $display("[FAIL] %0t bus access timed out", $time);
      tally_and_finish();
    end
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic settle;
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : settle
  // Expected next index for a cycle of six sets
  function automatic logic [5:0] nxt(input logic [5:0] i);
    return (i == 6'h5) ? 6'h0 : i + 6'h1;
  endfunction : nxt
  task automatic chk_state;
    chk_idx(set_index_o, exp_idx);
    chk_word(active_params_o, mem[exp_idx]);
  endtask : chk_state

  // Main sequence
  initial begin
    logic [31:0] q;
    logic [31:0] prior;
    logic [1:0]  lv;
    logic [1:0]  inv;
    logic [1:0]  a;
    int          mode;
    int          rsrc;
    srst_i = 1'b1;
    avs_address_i = 5'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    errors = 0;
    num_checks = 0;
    q = $urandom(32'h2369);
    repeat (16) @(posedge core_clk_i);
    srst_i <= 1'b0;
    bus(1'b0, CSA_REG_TOTAL, 32'h0, q);
    chk_word(q, {25'h0, CSA_TOTAL_RST});
    bus(1'b0, CSA_REG_ACTIVE, 32'h0, q);
    chk_word(q, CSA_ACTIVE_RST);
    bus(1'b0, 5'h1c, 32'h0, q);
    chk_word(q, 32'h0);
    prior = $urandom;
    wr(CSA_REG_ACTIVE, prior);
    wr(CSA_REG_TOTAL, 32'h6);
    wr(CSA_REG_TOTAL, 32'h0);
    wr(CSA_REG_TOTAL, 32'h41);
    bus(1'b0, CSA_REG_TOTAL, 32'h0, q);
    chk_word(q, 32'h6);
    for (int i = 0; i < 6; i++) begin
      mem[i] = $urandom;
      wr(CSA_REG_SETIDX, i);
      wr(CSA_REG_SETDAT, mem[i]);
    end
    bus(1'b0, CSA_REG_SETDAT, 32'h0, q);
    chk_word(q, mem[5]);
    // Always-active advance with wrap
    wr(CSA_REG_CTRL, 32'h1);
    settle();
    exp_idx = 6'h0;
    chk_state();
    chk_word({31'h0, waiting_trigger_o}, 32'h1);
    bus(1'b0, CSA_REG_STATUS, 32'h0, q);
    chk_word(q, {22'h0, 1'b1, 1'b1, 2'h0, 6'h0});
    for (int k = 0; k < 7; k++) begin
      i_csa_line_model.pulse();
      exp_idx = nxt(exp_idx);
      chk_state();
    end
    // Restart on line one wins over advance, then a trigger during settle
    wr(CSA_REG_CTRL, 32'h9);
    bus(1'b0, CSA_REG_CTRL, 32'h0, q);
    chk_word(q, 32'h9);
    i_csa_line_model.set_lines(2'h1);
    i_csa_line_model.pulse();
    exp_idx = 6'h0;
    chk_state();
    i_csa_line_model.glitch(2'h0);
    chk_state();
    // Random sources, restart lines, inversion, edges and software steps
    for (int k = 0; k < 30; k++) begin
      mode = $urandom_range(3);
      rsrc = (mode == 1) ? 2 : (mode == 2) ? 1 : (mode == 3) ? 0 : $urandom_range(2);
      inv = $urandom_range(3);
      wr(CSA_REG_CTRL, 1 | (mode << 1) | (rsrc << 3) | (inv << 5) | ($urandom_range(1) << 7));
      lv = $urandom_range(3);
      i_csa_line_model.set_lines(lv);
      a = lv ^ inv;
      if ($urandom_range(4) == 0) begin
        wr(CSA_REG_STEP, 32'h1);
        settle();
        exp_idx = nxt(exp_idx);
      end else begin
        i_csa_line_model.pulse();
        if (rsrc != 0 && a[rsrc-1]) exp_idx = 6'h0;
        else if (mode == 0 || (mode != 3 && a[mode-1])) exp_idx = nxt(exp_idx);
      end
      chk_state();
    end
    // Disable restores the earlier active word
    wr(CSA_REG_CTRL, 32'h0);
    settle();
    chk_word(active_params_o, prior);
    tally_and_finish();
  end
endmodule : csa_sequencer_tb

bind csa_sequencer csa_sequencer_asserts i_csa_sequencer_asserts (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .input_line_i(input_line_i), .set_index_o(set_index_o),
  .frame_accept_o(frame_accept_o), .waiting_trigger_o(waiting_trigger_o));
